// file: src/spcr_params.svh
// Purpose: Named constants of the power, clock and reset controller.
// Assumes: System clock of 20 MHz; offsets are byte addresses on the register bus.
// Notes: Definitions only.
`ifndef SPCR_PARAMS_SVH
`define SPCR_PARAMS_SVH
// ==========================================================================
// Timing
`define CLK_PERIOD_NS 50
`define WAKE_TIME_NS 35000
`define WAKE_CYC ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_HOLD_CYC 5'h10
`define SWITCH_GAP 2'h2
// ==========================================================================
// Register offsets
`define A_PWR_CTRL 7'h00
`define A_PWR_STAT 7'h04
`define A_CLK_SEL 7'h08
`define A_IMO_FREQ 7'h0c
`define A_FLL_CTRL 7'h10
`define A_WDT_CTRL 7'h14
`define A_WDT_MATCH 7'h18
`define A_WDT_COUNT 7'h1c
`define A_RST_CAUSE 7'h20
`define A_INT_STAT 7'h24
`define A_INT_EN 7'h28
`define A_INT_CLR 7'h2c
`define DIV_SEL 2'h2
// ==========================================================================
// Fields and reset values
`define NUM_DIV 8
`define NUM_FRAC_DIV 2
`define DIV_MASK 32'h801f_ffff
`define DIV_EN_BIT 31
`define FRAC_LSB 16
`define SWRST_BIT 8
`define MODE_SLEEP 2'h1
`define MODE_DEEP 2'h2
`define IMO_CODE_RST 3'h0
`define IMO_CODE_MAX 3'h6
`define IMO_TRIM_LSB 8
`define IMO_TRIM_RST 8'h80
`define FLL_TARGET_RST 16'h0200
`define WDT_MATCH_RST 16'hffff
`define CAUSE_EXT 0
`define CAUSE_BOD 1
`define CAUSE_WDT 2
`define CAUSE_SW 3
`define INT_WDT 0
`define INT_WAKE 1
`define INT_SWITCH 2
`define PIN_EXTERNAL_RESET_PIN 0
`define PIN_SUP 1
`define PIN_ILO 2
`define PIN_WCO 3
`define PIN_IMO 4
`endif

// file: src/spcr_pkg.sv
// Purpose: Types of the power, clock and reset controller.
// Assumes: Nothing beyond the constants header.
// Notes: Power states are Gray coded along Por, Active, Sleep and Wake.
package spcr_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_ACTIVE = 3'h1,
    ST_SLEEP = 3'h3,
    ST_DEEP = 3'h5,
    ST_WAKE = 3'h7
  } pwr_state_t;
endpackage

// file: src/periph_clk_divider.sv
// Purpose: One peripheral clock divider producing a one-cycle clock enable.
// Assumes: Runs on the system clock; run is low while peripheral clocks are off.
// Notes: Period is div_int + 1 cycles, plus one on fractional carry.
`timescale 1ns/1ns
`default_nettype none
module periph_clk_divider
  import spcr_pkg::*;
#(
  parameter bit FRAC_EN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic srst,
  input wire logic run,
  input wire logic enable,
  input wire logic [15:0] div_int,
  input wire logic [4:0] div_frac,
  output logic tick
);
  logic [15:0] cnt;
  logic [4:0] acc;
  logic extra;
  logic [5:0] next_acc;

  assign next_acc = {1'b0, acc} + {1'b0, div_frac};

  // ==========================================================================
  // Divider counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 16'h0;
      acc <= 5'h0;
      extra <= 1'b0;
      tick <= 1'b0;
    end else if (srst || !enable) begin
      cnt <= 16'h0;
      acc <= 5'h0;
      extra <= 1'b0;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (cnt != 16'h0) begin
      cnt <= cnt - 16'h1; // [R07]
      tick <= 1'b0;
    end else if (FRAC_EN && extra) begin
      extra <= 1'b0; // [R06]
      tick <= 1'b0;
    end else begin
      cnt <= div_int; // [R07]
      tick <= 1'b1; // [R06]
      if (FRAC_EN) begin
        acc <= next_acc[4:0];
        extra <= next_acc[5];
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_div_gap: assert property (tick && div_int != 16'h0 && !srst |=> !tick) // [R07]
    else $error("Divider ticked on two adjacent cycles.");
  a_div_stop: assert property (!run |=> !tick) // [R06]
    else $error("Divider ticked while peripheral clocks were stopped.");
endmodule // periph_clk_divider
`default_nettype wire

// file: src/system_power_clock_reset.sv
// Purpose: Power modes, clock gating and selection, dividers, oscillator trim,
//   watchdog and reset control for a small microcontroller.
// Assumes: One 20 MHz system clock; oscillator and pin inputs are asynchronous.
// Notes: Registers are reached over Avalon-MM with one wait state.
// What this block does
// R01 - Three power modes; Active clocks and runs every subsystem.
// R02 - Sleep gates processor and memory clocks, peripherals run, instant wake.
// R03 - Deep Sleep stops high-speed clock; wake-up takes 35 us.
// R04 - Hold mode entry until supply is good; brown-out causes reset.
// R05 - Clock source switching is glitch-free and free of metastability.
// R06 - Eight peripheral dividers from high-speed clock, two fractional.
// R07 - Each divider holds a 16-bit divide value.
// R08 - Main oscillator starts at 24 MHz, programmable 24 to 48 in 4 MHz steps.
// R09 - Low-power oscillator clocks watchdog and Deep Sleep peripherals.
// R10 - Main oscillator can be locked to the watch crystal reference.
// R11 - Watchdog counts through Deep Sleep and resets on unserviced timeout.
// R12 - Watchdog reset sets a watchdog flag in the reset-cause register.
// R13 - Watchdog counter can run from the watch crystal as a clock.
// R14 - Several reset sources including software; all logic returns to known state.
// R15 - Reset cause is recorded in a register not cleared by reset.
// R16 - Low level on the external reset pin requests reset.
// R17 - Servicing the watchdog restarts its count from zero.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`include "spcr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module system_power_clock_reset
  import spcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_reset_pin_n,
  input wire logic supply_ok,
  input wire logic low_power_oscillator,
  input wire logic watch_crystal_oscillator,
  input wire logic main_osc_ref,
  input wire logic wake_event,
  output logic system_reset_n,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic high_speed_system_clock_run,
  output logic clk_src_sel,
  output logic [2:0] main_internal_oscillator_code,
  output logic [7:0] main_internal_oscillator_trim,
  output logic lp_clk_tick,
  output logic [7:0] div_tick,
  output logic irq
);
  pwr_state_t state;
  pwr_state_t next_state;
  logic [4:0] pin_s1, pin_s2, pin_s3;
  logic ilo_tick, wco_tick, ref_tick;
  logic ack, wr, sw_rst, svc, srst;
  logic [4:0] rst_cnt;
  logic [3:0] cause, cause_set;
  logic [9:0] wake_cnt;
  logic src_req, src_act, gate;
  logic [1:0] sw_cnt;
  logic fll_en;
  logic [15:0] fll_target, ref_cnt;
  logic wdt_rst_en, wdt_wco, wdt_tick, wdt_hit, wdt_bite;
  logic [15:0] wdt_match, wdt_count;
  logic [2:0] int_stat, int_en, int_ev;
  logic [31:0] div_cfg [`NUM_DIV];
  logic [31:0] rd_mux;
  logic [31:0] wmerge;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    return a == off;
  endfunction

  // ==========================================================================
  // Pin and oscillator synchronisers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 5'h03;
      pin_s2 <= 5'h03;
      pin_s3 <= 5'h03;
    end else begin
      pin_s1 <= {main_osc_ref, watch_crystal_oscillator, low_power_oscillator, supply_ok,
                 external_reset_pin_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign ilo_tick = pin_s2[`PIN_ILO] && !pin_s3[`PIN_ILO];
  assign wco_tick = pin_s2[`PIN_WCO] && !pin_s3[`PIN_WCO];
  assign ref_tick = pin_s2[`PIN_IMO] && !pin_s3[`PIN_IMO];
  assign lp_clk_tick = ilo_tick; // [R09]

  // ==========================================================================
  // Register bus handshake
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr = avs_write && ack;
  assign wmerge = be_merge(32'h0, avs_writedata, avs_byteenable);
  assign sw_rst = wr && hit(avs_address, `A_PWR_CTRL) && wmerge[`SWRST_BIT]; // [R14]
  assign svc = wr && hit(avs_address, `A_WDT_COUNT);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack) begin
      avs_readdata <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (avs_address[6:5] == `DIV_SEL) begin
      rd_mux = div_cfg[avs_address[4:2]];
    end else begin
      case (avs_address)
        `A_PWR_STAT: rd_mux = {28'h0, pin_s2[`PIN_SUP], state};
        `A_CLK_SEL: rd_mux = {23'h0, src_act, 7'h0, src_req};
        `A_IMO_FREQ: rd_mux = {16'h0, main_internal_oscillator_trim, 5'h0,
                               main_internal_oscillator_code};
        `A_FLL_CTRL: rd_mux = {fll_target, 15'h0, fll_en};
        `A_WDT_CTRL: rd_mux = {30'h0, wdt_wco, wdt_rst_en};
        `A_WDT_MATCH: rd_mux = {16'h0, wdt_match};
        `A_WDT_COUNT: rd_mux = {16'h0, wdt_count};
        `A_RST_CAUSE: rd_mux = {28'h0, cause};
        `A_INT_STAT: rd_mux = {29'h0, int_stat};
        `A_INT_EN: rd_mux = {29'h0, int_en};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Reset sources, stretch and cause record
  assign cause_set[`CAUSE_EXT] = !pin_s2[`PIN_EXTERNAL_RESET_PIN]; // [R16]
  assign cause_set[`CAUSE_BOD] = !pin_s2[`PIN_SUP] && state != ST_POR; // [R04]
  assign cause_set[`CAUSE_WDT] = wdt_bite; // [R12]
  assign cause_set[`CAUSE_SW] = sw_rst;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_cnt <= `RST_HOLD_CYC;
    end else if (|cause_set) begin
      rst_cnt <= `RST_HOLD_CYC; // [R14]
    end else if (rst_cnt != 5'h0) begin
      rst_cnt <= rst_cnt - 5'h1;
    end
  end

  assign srst = rst_cnt != 5'h0;
  assign system_reset_n = !srst;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cause <= 4'h0;
    end else if (wr && hit(avs_address, `A_RST_CAUSE)) begin
      cause <= (cause & ~wmerge[3:0]) | cause_set; // [R15]
    end else begin
      cause <= cause | cause_set; // [R15]
    end
  end

  // ==========================================================================
  // Power mode state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_POR: if (pin_s2[`PIN_SUP]) next_state = ST_ACTIVE; // [R04]
      ST_ACTIVE: begin
        if (wr && hit(avs_address, `A_PWR_CTRL) && wmerge[1:0] == `MODE_SLEEP) begin
          next_state = ST_SLEEP;
        end else if (wr && hit(avs_address, `A_PWR_CTRL) && wmerge[1:0] == `MODE_DEEP) begin
          next_state = ST_DEEP;
        end
      end
      ST_SLEEP: if (wake_event) next_state = ST_ACTIVE; // [R02]
      ST_DEEP: if (wake_event) next_state = ST_WAKE; // [R03]
      ST_WAKE: if (wake_cnt == 10'h0) next_state = ST_ACTIVE; // [R03]
      default: next_state = ST_POR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_POR;
    end else if (srst) begin
      state <= ST_POR;
    end else begin
      state <= next_state; // [R01]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wake_cnt <= 10'h0;
    end else if (state == ST_DEEP) begin
      wake_cnt <= 10'(`WAKE_CYC - 1); // [R03]
    end else if (wake_cnt != 10'h0) begin
      wake_cnt <= wake_cnt - 10'h1;
    end
  end

  assign cpu_clk_en = state == ST_ACTIVE && gate; // [R01] [R02]
  assign periph_clk_en = (state == ST_ACTIVE || state == ST_SLEEP) && gate; // [R02]
  assign high_speed_system_clock_run = state != ST_DEEP; // [R03]

  // ==========================================================================
  // Glitch-free clock source switch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      src_req <= 1'b0;
    end else if (srst) begin
      src_req <= 1'b0;
    end else if (wr && hit(avs_address, `A_CLK_SEL) && avs_byteenable[0]) begin
      src_req <= avs_writedata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      src_act <= 1'b0;
      gate <= 1'b1;
      sw_cnt <= 2'h0;
    end else if (srst) begin
      src_act <= 1'b0;
      gate <= 1'b1;
      sw_cnt <= 2'h0;
    end else if (gate) begin
      if (src_act != src_req) begin
        gate <= 1'b0; // [R05]
        sw_cnt <= `SWITCH_GAP;
      end
    end else if (sw_cnt != 2'h0) begin
      sw_cnt <= sw_cnt - 2'h1;
    end else if (src_act != src_req) begin
      src_act <= src_req; // [R05]
      sw_cnt <= `SWITCH_GAP;
    end else begin
      gate <= 1'b1;
    end
  end

  assign clk_src_sel = src_act;

  // ==========================================================================
  // Main oscillator frequency and lock to the watch crystal
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_internal_oscillator_code <= `IMO_CODE_RST;
      main_internal_oscillator_trim <= `IMO_TRIM_RST;
      fll_en <= 1'b0;
      fll_target <= `FLL_TARGET_RST;
      ref_cnt <= 16'h0;
    end else if (srst) begin
      main_internal_oscillator_code <= `IMO_CODE_RST; // [R08]
      main_internal_oscillator_trim <= `IMO_TRIM_RST;
      fll_en <= 1'b0;
      fll_target <= `FLL_TARGET_RST;
      ref_cnt <= 16'h0;
    end else begin
      if (wr && hit(avs_address, `A_IMO_FREQ)) begin
        if (avs_byteenable[0]) begin
          main_internal_oscillator_code <= (avs_writedata[2:0] > `IMO_CODE_MAX) ?
            `IMO_CODE_MAX : avs_writedata[2:0]; // [R08]
        end
        if (avs_byteenable[1]) begin
          main_internal_oscillator_trim <= avs_writedata[`IMO_TRIM_LSB +: 8];
        end
      end else if (fll_en && wco_tick) begin
        if (ref_cnt < fll_target && main_internal_oscillator_trim != 8'hff) begin
          main_internal_oscillator_trim <= main_internal_oscillator_trim + 8'h1; // [R10]
        end else if (ref_cnt > fll_target && main_internal_oscillator_trim != 8'h00) begin
          main_internal_oscillator_trim <= main_internal_oscillator_trim - 8'h1; // [R10]
        end
      end
      if (wr && hit(avs_address, `A_FLL_CTRL)) begin
        fll_en <= avs_byteenable[0] ? avs_writedata[0] : fll_en;
        fll_target <= 16'(be_merge({fll_target, 16'h0}, avs_writedata, avs_byteenable) >> 16);
      end
      if (wco_tick) begin
        ref_cnt <= 16'h0;
      end else if (ref_tick && ref_cnt != 16'hffff) begin
        ref_cnt <= ref_cnt + 16'h1;
      end
    end
  end

  // ==========================================================================
  // Watchdog counter
  assign wdt_tick = wdt_wco ? wco_tick : ilo_tick; // [R09] [R13]
  assign wdt_hit = wdt_tick && wdt_count == wdt_match;
  assign wdt_bite = wdt_hit && wdt_rst_en && !svc; // [R11]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdt_rst_en <= 1'b0;
      wdt_wco <= 1'b0;
      wdt_match <= `WDT_MATCH_RST;
    end else if (srst) begin
      wdt_rst_en <= 1'b0;
      wdt_wco <= 1'b0;
      wdt_match <= `WDT_MATCH_RST;
    end else begin
      if (wr && hit(avs_address, `A_WDT_CTRL) && avs_byteenable[0]) begin
        wdt_rst_en <= avs_writedata[0];
        wdt_wco <= avs_writedata[1];
      end
      if (wr && hit(avs_address, `A_WDT_MATCH)) begin
        wdt_match <= 16'(be_merge({16'h0, wdt_match}, avs_writedata, avs_byteenable));
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdt_count <= 16'h0;
    end else if (srst || svc) begin
      wdt_count <= 16'h0; // [R17]
    end else if (wdt_hit) begin
      wdt_count <= 16'h0;
    end else if (wdt_tick) begin
      wdt_count <= wdt_count + 16'h1; // [R11]
    end
  end

  // ==========================================================================
  // Interrupt status, enable and clear
  assign int_ev[`INT_WDT] = wdt_hit;
  assign int_ev[`INT_WAKE] = state == ST_WAKE && next_state == ST_ACTIVE;
  assign int_ev[`INT_SWITCH] = !gate && sw_cnt == 2'h0 && src_act == src_req;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      int_stat <= 3'h0;
      int_en <= 3'h0;
    end else if (srst) begin
      int_stat <= 3'h0;
      int_en <= 3'h0;
    end else begin
      if (wr && hit(avs_address, `A_INT_CLR)) begin
        int_stat <= (int_stat & ~wmerge[2:0]) | int_ev;
      end else begin
        int_stat <= int_stat | int_ev;
      end
      if (wr && hit(avs_address, `A_INT_EN) && avs_byteenable[0]) begin
        int_en <= avs_writedata[2:0];
      end
    end
  end

  assign irq = |(int_stat & int_en);

  // ==========================================================================
  // Peripheral clock dividers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `NUM_DIV; i++) begin
        div_cfg[i] <= 32'h0;
      end
    end else if (srst) begin
      for (int i = 0; i < `NUM_DIV; i++) begin
        div_cfg[i] <= 32'h0;
      end
    end else if (wr && avs_address[6:5] == `DIV_SEL) begin
      div_cfg[avs_address[4:2]] <= be_merge(div_cfg[avs_address[4:2]], avs_writedata,
                                            avs_byteenable) & `DIV_MASK; // [R07]
    end
  end

  for (genvar g = 0; g < `NUM_DIV; g++) begin : g_div
    periph_clk_divider #(
      .FRAC_EN(g < `NUM_FRAC_DIV)
    ) u_div (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .srst(srst),
      .run(periph_clk_en),
      .enable(div_cfg[g][`DIV_EN_BIT]),
      .div_int(div_cfg[g][15:0]),
      .div_frac(div_cfg[g][`FRAC_LSB +: 5]),
      .tick(div_tick[g])
    ); // [R06]
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_switch_start;
    gate && src_act != src_req && !srst;
  endsequence

  a_active_run: assert property (state == ST_ACTIVE && gate |-> cpu_clk_en && periph_clk_en
    && high_speed_system_clock_run) // [R01]
    else $error("Active mode without all clocks running.");
  a_sleep_gate: assert property (state == ST_SLEEP |-> !cpu_clk_en) // [R02]
    else $error("Processor clock running in sleep.");
  a_sleep_wake: assert property (state == ST_SLEEP && wake_event && !srst
    |=> state == ST_ACTIVE) // [R02]
    else $error("Sleep did not wake on the next cycle.");
  a_deep_wake: assert property (state == ST_DEEP && wake_event && !srst
    |=> (state == ST_WAKE && !cpu_clk_en) [*8]) // [R03]
    else $error("Deep sleep wake-up shorter than expected.");
  a_wake_end: assert property (state == ST_WAKE && wake_cnt == 10'h0 && !srst
    |=> state == ST_ACTIVE && $past(wake_cnt, 2) == 10'h1) // [R03]
    else $error("Wake-up did not finish after its count.");
  a_por_hold: assert property (state == ST_POR && !pin_s2[`PIN_SUP] |=> state == ST_POR) // [R04]
    else $error("Left power-on reset with supply low.");
  a_bod_reset: assert property (state != ST_POR && !pin_s2[`PIN_SUP]
    |=> !system_reset_n && cause[`CAUSE_BOD]) // [R04]
    else $error("Brown-out did not reset.");
  a_clk_switch: assert property (s_switch_start |=> !gate [*6] ##1 gate) // [R05]
    else $error("Clock switch not gated around the change.");
  a_src_stable: assert property ($changed(src_act) && !$past(srst)
    |-> !gate && !$past(gate)) // [R05]
    else $error("Clock source changed while gate open.");
  a_imo_range: assert property (main_internal_oscillator_code <= `IMO_CODE_MAX) // [R08]
    else $error("Main oscillator code out of range.");
  a_wdt_bite: assert property (wdt_bite |=> !system_reset_n && cause[`CAUSE_WDT]) // [R11] [R12]
    else $error("Watchdog timeout did not reset and record.");
  a_wdt_service: assert property (svc |=> wdt_count == 16'h0) // [R17]
    else $error("Watchdog service did not restart the count.");
  a_cause_keep: assert property (srst && |cause && !(wr && avs_address == `A_RST_CAUSE)
    |=> (cause & $past(cause)) == $past(cause)) // [R15]
    else $error("Reset cause lost during reset.");
  a_ext_reset: assert property (!pin_s2[`PIN_EXTERNAL_RESET_PIN] |=> !system_reset_n && cause[`CAUSE_EXT]) // [R16]
    else $error("External reset pin not honoured.");
endmodule // system_power_clock_reset
`default_nettype wire

// file: sim/system_power_clock_reset_tb_top.sv
// Purpose: Self-checking bench of the power, clock and reset controller.
// Assumes: 20 MHz clock; register map of the constants header.
// Notes: One Avalon task reaches every register.
`include "spcr_params.svh"
`timescale 1ns/1ns
`default_nettype none
module system_power_clock_reset_tb_top
  import spcr_pkg::*;
;
  // ==========
  // Signals
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, wake_event = 1'b0, seen = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic external_reset_pin_n = 1'b1, supply_ok = 1'b1, low_power_oscillator = 1'b0;
  logic watch_crystal_oscillator = 1'b0, main_osc_ref = 1'b0;
  logic avs_waitrequest, system_reset_n, cpu_clk_en, periph_clk_en, irq, clk_src_sel;
  logic high_speed_system_clock_run, lp_clk_tick;
  logic [2:0] main_internal_oscillator_code;
  logic [7:0] main_internal_oscillator_trim, div_tick;
  int bad_count = 0, check_count = 0, n;
  system_power_clock_reset system_power_clock_reset_i (.clk_sys, .nrst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .external_reset_pin_n, .supply_ok, .low_power_oscillator,
    .watch_crystal_oscillator, .main_osc_ref, .wake_event, .system_reset_n, .cpu_clk_en,
    .periph_clk_en, .high_speed_system_clock_run, .clk_src_sel,
    .main_internal_oscillator_code, .main_internal_oscillator_trim, .lp_clk_tick,
    .div_tick, .irq);
  always #25 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (system_reset_n === 1'b0) seen = 1'b1;
  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic lpo(input int e);
    repeat (e) begin
      @(posedge clk_sys) {watch_crystal_oscillator, low_power_oscillator} <= 2'h3;
      repeat (4) @(posedge clk_sys);
      {watch_crystal_oscillator, low_power_oscillator} <= 2'h0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task automatic cause_chk(input logic [31:0] c);
    n = 0;
    while ((seen !== 1'b1 || system_reset_n !== 1'b1) && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk("reset", {31'h0, seen}, 32'h1);
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `A_RST_CAUSE, 32'h0);
    chk("cause", q, c);
    bus(1'b1, `A_RST_CAUSE, 32'hf);
    seen = 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    bus(1'b0, `A_PWR_STAT, 32'h0);
    chk("pwr_stat", q, 32'h9);
    chk("enables", {29'h0, cpu_clk_en, periph_clk_en, high_speed_system_clock_run}, 32'h7);
    bus(1'b0, `A_IMO_FREQ, 32'h0);
    chk("imo_rst", q, 32'h8000);
    bus(1'b0, 7'h3c, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, `A_IMO_FREQ, 32'h8007);
    bus(1'b0, `A_IMO_FREQ, 32'h0);
    chk("imo_max", q, 32'h8006);
    chk("imo_code", {29'h0, main_internal_oscillator_code}, 32'h6);
    $display("reset and oscillator test done");
  endtask
  task automatic t_power();
    bus(1'b1, `A_PWR_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("sleep", {30'h0, cpu_clk_en, periph_clk_en}, 32'h1);
    @(posedge clk_sys) wake_event <= 1'b1;
    @(posedge clk_sys) wake_event <= 1'b0;
    @(negedge clk_sys);
    chk("sleep_wake", {31'h0, cpu_clk_en}, 32'h1);
    bus(1'b1, `A_INT_CLR, 32'h7);
    bus(1'b1, `A_INT_EN, 32'h2);
    bus(1'b1, `A_PWR_CTRL, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("deep", {29'h0, cpu_clk_en, periph_clk_en, high_speed_system_clock_run}, 32'h0);
    @(posedge clk_sys) wake_event <= 1'b1;
    @(posedge clk_sys) wake_event <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 2000);
    chk("wake_cycles", n, 32'd701);
    chk("irq_set", {31'h0, irq}, 32'h1);
    bus(1'b1, `A_INT_EN, 32'h0);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    bus(1'b1, `A_INT_EN, 32'h2);
    bus(1'b1, `A_INT_CLR, 32'h2);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    $display("power mode test done");
  endtask
  task automatic t_switch();
    logic p;
    int g;
    g = 0;
    p = clk_src_sel;
    bus(1'b1, `A_CLK_SEL, 32'h1);
    repeat (12) begin
      @(negedge clk_sys);
      if (clk_src_sel !== p && {cpu_clk_en, periph_clk_en} !== 2'b00) g++;
      p = clk_src_sel;
    end
    chk("open_switch", g, 32'h0);
    chk("src", {30'h0, clk_src_sel, cpu_clk_en}, 32'h3);
    bus(1'b0, `A_INT_STAT, 32'h0);
    chk("int_stat", q, 32'h4);
    $display("clock switch test done");
  endtask
  task automatic t_div();
    int m;
    m = 0;
    bus(1'b1, 7'h40, 32'h8000_0003);
    bus(1'b1, 7'h44, 32'h8010_0001);
    n = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (div_tick[0] === 1'b1) n++;
      if (div_tick[1] === 1'b1) m++;
    end
    chk("div_ticks", n, 32'd10);
    chk("frac_ticks", m, 32'd16);
    bus(1'b1, 7'h5c, 32'h0000_ffff);
    bus(1'b0, 7'h5c, 32'h0);
    chk("div_width", q, 32'h0000_ffff);
    $display("divider test done");
  endtask
  task automatic t_wdt();
    bus(1'b1, `A_FLL_CTRL, 32'h0200_0001);
    bus(1'b1, `A_WDT_MATCH, 32'h3);
    bus(1'b1, `A_WDT_CTRL, 32'h1);
    bus(1'b1, `A_WDT_COUNT, 32'h0);
    lpo(2);
    bus(1'b1, `A_WDT_COUNT, 32'h0);
    lpo(2);
    chk("serviced", {31'h0, seen}, 32'h0);
    chk("trim", {24'h0, main_internal_oscillator_trim}, 32'h84);
    lpo(2);
    cause_chk(32'h4);
    $display("watchdog test done");
  endtask
  task automatic t_sources();
    bus(1'b1, `A_PWR_CTRL, 32'h100);
    cause_chk(32'h8);
    @(posedge clk_sys) external_reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    external_reset_pin_n <= 1'b1;
    cause_chk(32'h1);
    @(posedge clk_sys) supply_ok <= 1'b0;
    repeat (4) @(posedge clk_sys);
    supply_ok <= 1'b1;
    cause_chk(32'h2);
    $display("reset source test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    bus(1'b1, `A_RST_CAUSE, 32'hf);
    seen = 1'b0;
    t_reset();
    t_power();
    t_switch();
    t_div();
    t_wdt();
    t_sources();
    final_report();
  end
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule // system_power_clock_reset_tb_top
`default_nettype wire
